/* File: include/pat_pkg.sv */
// paged_address_translator package: constants, commands, carriers
// assumes one clock domain and a synchronous active-low reset
package pat_pkg;
  // ==================================================
  // sizes
  localparam int ENTRIES = 64;      // translation cache entries
  localparam int RPT_N = 8;         // root pointer table entries
  localparam int BKPT_N = 8;        // breakpoint channels
  localparam int PAGE_SHIFT_MIN = 8; // 256-byte smallest page
  // ==================================================
  // register move selects
  localparam logic [4:0] SEL_TC = 5'h00;   // page size in [2:0]
  localparam logic [4:0] SEL_AC = 5'h01;   // level lines in [1:0]
  localparam logic [4:0] SEL_CAL = 5'h02;  // current level [2:0]
  localparam logic [4:0] SEL_ROOT = 5'h03; // table root pointer
  localparam logic [4:0] SEL_PSR = 5'h04;  // status, write clears
  localparam logic [4:0] SEL_BAD = 5'h08;  // 8..15 opcodes
  localparam logic [4:0] SEL_BAC = 5'h10;  // 16..23 [8]en [7:0]n
  // ==================================================
  // status bits, descriptor bits, breakpoint control enable bit
  localparam int PSR_MISS = 0;
  localparam int PSR_WP = 1;
  localparam int PSR_PRIV = 2;
  localparam int PSR_MOD = 3;
  localparam int PSR_USED = 4;
  localparam int PSR_SH = 5;
  localparam int D_OK = 0;
  localparam int D_WP = 1;
  localparam int D_USED = 3;
  localparam int D_MOD = 4;
  localparam int D_SH = 5;
  localparam int BAC_EN = 8;
  // breakpoint acknowledge decode
  localparam logic [3:0] FC_CPU = 4'h7;
  localparam logic [3:0] BKPT_TYPE = 4'h0;
  // ==================================================
  // commands
  typedef enum logic [3:0] {
    OP_MOVE_RD = 4'h0, OP_MOVE_WR = 4'h1, OP_VALID = 4'h2,
    OP_TEST_R = 4'h3, OP_TEST_W = 4'h4, OP_LOAD_R = 4'h5,
    OP_LOAD_W = 4'h6, OP_FL_FC = 4'h7, OP_FL_FCA = 4'h8,
    OP_FL_ALL = 4'h9, OP_FL_ROOT = 4'hA, OP_FL_SFC = 4'hB,
    OP_FL_SFCA = 4'hC, OP_SAVE = 4'hD, OP_RESTORE = 4'hE,
    OP_COND = 4'hF
  } pat_op_t;
  // walker states, gray along idle-walk-hist-fill
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WALK = 2'b01, ST_HIST = 2'b11, ST_FILL = 2'b10
  } pat_state_t;
  // ==================================================
  // carriers
  typedef struct packed {
    logic valid; logic write; logic [3:0] fc; logic [31:0] addr;
  } pat_lreq_t;
  typedef struct packed {
    logic pa_valid; logic dsack; logic berr; logic retry;
    logic [31:0] pa; logic [15:0] data;
  } pat_lrsp_t;
  typedef struct packed {
    logic valid; pat_op_t op; logic [4:0] sel; logic [3:0] fc;
    logic [31:0] addr; logic [31:0] data;
  } pat_creq_t;
  typedef struct packed {
    logic done; logic cond; logic trap; logic [31:0] rdata;
  } pat_crsp_t;
  typedef struct packed {
    logic req; logic we; logic [31:0] addr; logic [31:0] wdata;
  } pat_treq_t;
  typedef struct packed {
    logic valid; logic ok; logic wp; logic md; logic sh; logic nru;
    logic [3:0] fc; logic [2:0] als; logic [23:0] vpn; logic [23:0] frm;
  } pat_entry_t;
  typedef struct packed {
    logic [31:0] addr; logic [3:0] fc; logic write; pat_op_t op;
    logic cmd;
  } pat_walk_t;
  typedef struct packed {
    logic en; logic [7:0] cnt;
  } pat_bac_t;
endpackage

/* File: src/pat_top.sv */
// paged_address_translator: translation cache, walker, privilege,
// breakpoint acknowledge and maintenance commands
// assumes requests come from logic on CLK_SYS and are held to answer
`timescale 1ns/10ps
module pat_top #(
  parameter int ENTRIES = pat_pkg::ENTRIES
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // logical bus master
  input wire pat_pkg::pat_lreq_t LA_REQ,
  output pat_pkg::pat_lrsp_t LA_RSP,
  // command port from processor side
  input wire pat_pkg::pat_creq_t CMD_REQ,
  output pat_pkg::pat_crsp_t CMD_RSP,
  // physical table walk bus
  output pat_pkg::pat_treq_t TW_REQ,
  input wire logic TW_ACK,
  input wire logic [31:0] TW_RDATA
);
  localparam int IW = $clog2(ENTRIES);
  // ==================================================
  // state
  pat_pkg::pat_state_t st_reg, st_next;            // walker state
  pat_pkg::pat_entry_t cache_reg [ENTRIES];        // translation cache
  pat_pkg::pat_entry_t cache_next [ENTRIES];
  logic [31:0] rpt_reg [pat_pkg::RPT_N];           // cached roots
  logic [31:0] rpt_next [pat_pkg::RPT_N];
  logic [pat_pkg::RPT_N-1:0] rptv_reg, rptv_next;  // root valid
  logic [15:0] bad_reg [pat_pkg::BKPT_N];          // opcodes
  logic [15:0] bad_next [pat_pkg::BKPT_N];
  pat_pkg::pat_bac_t bac_reg [pat_pkg::BKPT_N];    // enable, count
  pat_pkg::pat_bac_t bac_next [pat_pkg::BKPT_N];
  logic [2:0] ps_reg, ps_next;                     // page size code
  logic [1:0] lvl_reg, lvl_next;                   // level lines
  logic [2:0] cal_reg, cal_next;                   // current level
  logic [31:0] root_reg, root_next;                // active root
  logic [2:0] als_reg, als_next;                   // active alias
  logic [2:0] rptr_reg, rptr_next;                 // root replace ptr
  logic [15:0] psr_reg, psr_next;                  // test status
  logic [31:0] desc_reg, desc_next;                // fetched descriptor
  pat_pkg::pat_walk_t wk_reg, wk_next;             // walk context
  pat_pkg::pat_lrsp_t lrsp_reg, lrsp_next;
  pat_pkg::pat_crsp_t crsp_reg, crsp_next;
  pat_pkg::pat_treq_t treq_reg, treq_next;
  // ==================================================
  // lookup wires
  logic [31:0] lk_addr;      // address being looked up
  logic [3:0] lk_fc;
  logic [23:0] pmask;        // offset bits within page number
  logic hit;
  logic [IW-1:0] hit_idx, vic_idx;
  logic got_free, got_nru;
  logic la_take, cmd_take;

  assign LA_RSP = lrsp_reg;
  assign CMD_RSP = crsp_reg;
  assign TW_REQ = treq_reg;

  // level check: higher privilege is a lower number
  function automatic logic priv_bad(input logic [2:0] req,
      input logic [1:0] md, input logic [2:0] cal);
    logic [1:0] sh;
    sh = 2'h3 - md;
    return (md != 2'h0) && ((req >> sh) < (cal >> sh));
  endfunction

  // ==================================================
  // request arbitration, bus master has priority
  assign la_take = (st_reg == pat_pkg::ST_IDLE) && LA_REQ.valid &&
      !(lrsp_reg.pa_valid | lrsp_reg.dsack | lrsp_reg.berr | lrsp_reg.retry);
  assign cmd_take = (st_reg == pat_pkg::ST_IDLE) && !LA_REQ.valid &&
      CMD_REQ.valid && !crsp_reg.done;
  // lookup source
  assign lk_addr = (st_reg != pat_pkg::ST_IDLE) ? wk_reg.addr :
      (LA_REQ.valid ? LA_REQ.addr : CMD_REQ.addr);
  assign lk_fc = (st_reg != pat_pkg::ST_IDLE) ? wk_reg.fc :
      (LA_REQ.valid ? LA_REQ.fc : CMD_REQ.fc);
  assign pmask = ~(24'hFFFFFF << ps_reg);

  // associative search and victim pick
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    vic_idx = '0;
    got_free = 1'b0;
    got_nru = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      // tag is page number, function code and task alias
      if (!hit && cache_reg[i].valid && cache_reg[i].fc == lk_fc &&
          cache_reg[i].vpn == (lk_addr[31:8] & ~pmask) &&
          (cache_reg[i].sh || cache_reg[i].als == als_reg)) begin
        hit = 1'b1;
        hit_idx = IW'(i);
      end
      // first free slot, else first not recently used
      if (!got_free && !cache_reg[i].valid) begin
        got_free = 1'b1;
        vic_idx = IW'(i);
      end else if (!got_free && !got_nru && !cache_reg[i].nru) begin
        got_nru = 1'b1;
        vic_idx = IW'(i);
      end
    end
    if (hit) begin
      vic_idx = hit_idx; // refresh an existing entry in place
    end
  end

  // ==================================================
  // next-state logic for everything
  always_comb begin
    logic touch;
    logic [IW-1:0] tidx;
    logic [2:0] bn;
    logic all_used;
    logic am;
    logic [23:0] fr;
    touch = 1'b0;
    tidx = '0;
    bn = LA_REQ.addr[4:2];
    all_used = 1'b1;
    am = 1'b0;
    fr = '0;
    st_next = st_reg;
    cache_next = cache_reg;
    rpt_next = rpt_reg;
    rptv_next = rptv_reg;
    bad_next = bad_reg;
    bac_next = bac_reg;
    ps_next = ps_reg;
    lvl_next = lvl_reg;
    cal_next = cal_reg;
    root_next = root_reg;
    als_next = als_reg;
    rptr_next = rptr_reg;
    psr_next = psr_reg;
    desc_next = desc_reg;
    wk_next = wk_reg;
    lrsp_next = '0;
    lrsp_next.pa = lrsp_reg.pa;
    crsp_next = '0;
    crsp_next.rdata = crsp_reg.rdata;
    treq_next = treq_reg;
    unique case (st_reg)
      pat_pkg::ST_IDLE: begin
        if (la_take) begin
          if (LA_REQ.fc == pat_pkg::FC_CPU &&
              LA_REQ.addr[19:16] == pat_pkg::BKPT_TYPE) begin
            // breakpoint acknowledge
            if (bac_reg[bn].en && bac_reg[bn].cnt != 8'h00) begin
              lrsp_next.dsack = 1'b1;
              lrsp_next.data = bad_reg[bn];
              bac_next[bn].cnt = bac_reg[bn].cnt - 8'h01;
            end else begin
              lrsp_next.berr = 1'b1;
            end
          end else if (priv_bad(LA_REQ.addr[31:29], lvl_reg, cal_reg)) begin
            lrsp_next.berr = 1'b1; // no address issued
          end else if (hit && !(LA_REQ.write && !cache_reg[hit_idx].md &&
              cache_reg[hit_idx].ok)) begin
            if (!cache_reg[hit_idx].ok ||
                (LA_REQ.write && cache_reg[hit_idx].wp)) begin
              lrsp_next.berr = 1'b1; // faulted page
            end else begin
              fr = (cache_reg[hit_idx].frm & ~pmask) |
                  (LA_REQ.addr[31:8] & pmask);
              lrsp_next.pa_valid = 1'b1;
              lrsp_next.pa = {fr, LA_REQ.addr[7:0]};
            end
            touch = 1'b1;
            tidx = hit_idx;
          end else begin
            // miss, or first write to clean page: abort and walk
            lrsp_next.retry = 1'b1;
            wk_next = '{LA_REQ.addr, LA_REQ.fc, LA_REQ.write,
                LA_REQ.write ? pat_pkg::OP_LOAD_W : pat_pkg::OP_LOAD_R, 1'b0};
            st_next = pat_pkg::ST_WALK;
          end
        end else if (cmd_take) begin
          crsp_next.done = 1'b1;
          wk_next = '{CMD_REQ.addr, CMD_REQ.fc,
              CMD_REQ.op == pat_pkg::OP_TEST_W ||
              CMD_REQ.op == pat_pkg::OP_LOAD_W, CMD_REQ.op, 1'b1};
          unique case (CMD_REQ.op)
            pat_pkg::OP_MOVE_RD: begin
              crsp_next.rdata = '0;
              if (CMD_REQ.sel == pat_pkg::SEL_TC) crsp_next.rdata[2:0] = ps_reg;
              if (CMD_REQ.sel == pat_pkg::SEL_AC) crsp_next.rdata[1:0] = lvl_reg;
              if (CMD_REQ.sel == pat_pkg::SEL_CAL) crsp_next.rdata[2:0] = cal_reg;
              if (CMD_REQ.sel == pat_pkg::SEL_ROOT) crsp_next.rdata = root_reg;
              if (CMD_REQ.sel == pat_pkg::SEL_PSR) crsp_next.rdata[15:0] = psr_reg;
              if (CMD_REQ.sel[4:3] == pat_pkg::SEL_BAD[4:3])
                crsp_next.rdata[15:0] = bad_reg[CMD_REQ.sel[2:0]];
              if (CMD_REQ.sel[4:3] == pat_pkg::SEL_BAC[4:3])
                crsp_next.rdata[8:0] = bac_reg[CMD_REQ.sel[2:0]];
            end
            pat_pkg::OP_MOVE_WR: begin
              if (CMD_REQ.sel == pat_pkg::SEL_TC) ps_next = CMD_REQ.data[2:0];
              if (CMD_REQ.sel == pat_pkg::SEL_AC) lvl_next = CMD_REQ.data[1:0];
              if (CMD_REQ.sel == pat_pkg::SEL_CAL) cal_next = CMD_REQ.data[2:0];
              if (CMD_REQ.sel == pat_pkg::SEL_PSR) psr_next = '0;
              if (CMD_REQ.sel[4:3] == pat_pkg::SEL_BAD[4:3])
                bad_next[CMD_REQ.sel[2:0]] = CMD_REQ.data[15:0];
              if (CMD_REQ.sel[4:3] == pat_pkg::SEL_BAC[4:3])
                bac_next[CMD_REQ.sel[2:0]] = CMD_REQ.data[8:0];
              if (CMD_REQ.sel == pat_pkg::SEL_ROOT) begin
                // reuse a cached root alias or evict the oldest
                root_next = CMD_REQ.data;
                am = 1'b0;
                for (int j = 0; j < pat_pkg::RPT_N; j++) begin
                  if (!am && rptv_reg[j] && rpt_reg[j] == CMD_REQ.data) begin
                    am = 1'b1;
                    als_next = 3'(j);
                  end
                end
                if (!am) begin
                  als_next = rptr_reg;
                  rpt_next[rptr_reg] = CMD_REQ.data;
                  rptv_next[rptr_reg] = 1'b1;
                  rptr_next = rptr_reg + 3'h1;
                  for (int i = 0; i < ENTRIES; i++) begin
                    if (!cache_reg[i].sh && cache_reg[i].als == rptr_reg)
                      cache_next[i].valid = 1'b0;
                  end
                end
              end
            end
            pat_pkg::OP_VALID: begin
              crsp_next.trap = priv_bad(CMD_REQ.addr[31:29], lvl_reg,
                  cal_reg);
            end
            pat_pkg::OP_TEST_R, pat_pkg::OP_TEST_W, pat_pkg::OP_LOAD_R,
            pat_pkg::OP_LOAD_W: begin
              crsp_next.done = 1'b0; // answered after the walk
              st_next = pat_pkg::ST_WALK;
            end
            pat_pkg::OP_FL_ROOT: begin
              // drop the root and entries under its alias
              for (int j = 0; j < pat_pkg::RPT_N; j++) begin
                if (rptv_reg[j] && rpt_reg[j] == CMD_REQ.data) begin
                  rptv_next[j] = 1'b0;
                  for (int i = 0; i < ENTRIES; i++) begin
                    if (!cache_reg[i].sh && cache_reg[i].als == 3'(j))
                      cache_next[i].valid = 1'b0;
                  end
                end
              end
            end
            pat_pkg::OP_SAVE: begin
              crsp_next.rdata = {21'h0, als_reg, cal_reg, lvl_reg,
                  ps_reg};
            end
            pat_pkg::OP_RESTORE: begin
              {als_next, cal_next, lvl_next, ps_next} =
                  CMD_REQ.data[10:0];
            end
            pat_pkg::OP_COND: begin
              crsp_next.cond = psr_reg[CMD_REQ.data[3:0]] ^
                  CMD_REQ.data[4];
            end
            default: begin
              // flush family
              for (int i = 0; i < ENTRIES; i++) begin
                am = cache_reg[i].vpn == (CMD_REQ.addr[31:8] & ~pmask);
                if (CMD_REQ.op == pat_pkg::OP_FL_ALL)
                  cache_next[i].valid = 1'b0;
                if (cache_reg[i].fc == CMD_REQ.fc) begin
                  if (CMD_REQ.op == pat_pkg::OP_FL_FC ||
                      (CMD_REQ.op == pat_pkg::OP_FL_FCA && am))
                    cache_next[i].valid = 1'b0;
                  if (cache_reg[i].sh && (CMD_REQ.op == pat_pkg::OP_FL_SFC ||
                      (CMD_REQ.op == pat_pkg::OP_FL_SFCA && am)))
                    cache_next[i].valid = 1'b0;
                end
              end
            end
          endcase
          if (CMD_REQ.op inside {pat_pkg::OP_TEST_R, pat_pkg::OP_TEST_W,
              pat_pkg::OP_LOAD_R, pat_pkg::OP_LOAD_W}) begin
            treq_next = '{1'b1, 1'b0, root_reg +
                {6'h0, CMD_REQ.addr[31:8] >> ps_reg, 2'h0}, 32'h0};
          end
        end
        if (la_take && lrsp_next.retry) begin
          treq_next = '{1'b1, 1'b0, root_reg +
              {6'h0, LA_REQ.addr[31:8] >> ps_reg, 2'h0}, 32'h0};
        end
      end
      pat_pkg::ST_WALK: begin
        if (TW_ACK) begin
          desc_next = TW_RDATA;
          treq_next.req = 1'b0;
          if (wk_reg.op == pat_pkg::OP_TEST_R ||
              wk_reg.op == pat_pkg::OP_TEST_W) begin
            // status only, cache untouched
            psr_next = '0;
            psr_next[pat_pkg::PSR_MISS] = !TW_RDATA[pat_pkg::D_OK];
            psr_next[pat_pkg::PSR_WP] = TW_RDATA[pat_pkg::D_WP] & wk_reg.write;
            psr_next[pat_pkg::PSR_MOD] = TW_RDATA[pat_pkg::D_MOD];
            psr_next[pat_pkg::PSR_USED] = TW_RDATA[pat_pkg::D_USED];
            psr_next[pat_pkg::PSR_SH] = TW_RDATA[pat_pkg::D_SH];
            psr_next[pat_pkg::PSR_PRIV] = priv_bad(wk_reg.addr[31:29],
                lvl_reg, cal_reg);
            crsp_next.done = 1'b1;
            st_next = pat_pkg::ST_IDLE;
          end else if (TW_RDATA[pat_pkg::D_OK]) begin
            // history write-back: used, and modified for writes
            treq_next.req = 1'b1;
            treq_next.we = 1'b1;
            treq_next.wdata = TW_RDATA;
            treq_next.wdata[pat_pkg::D_USED] = 1'b1;
            if (wk_reg.write) treq_next.wdata[pat_pkg::D_MOD] = 1'b1;
            desc_next = treq_next.wdata;
            st_next = pat_pkg::ST_HIST;
          end else begin
            st_next = pat_pkg::ST_FILL; // fault entry, answers bus error
          end
        end
      end
      pat_pkg::ST_HIST: begin
        if (TW_ACK) begin
          treq_next.req = 1'b0;
          treq_next.we = 1'b0;
          st_next = pat_pkg::ST_FILL;
        end
      end
      pat_pkg::ST_FILL: begin
        // load descriptor into the cache, master then retries
        cache_next[vic_idx] = '{1'b1, desc_reg[pat_pkg::D_OK],
            desc_reg[pat_pkg::D_WP], desc_reg[pat_pkg::D_MOD],
            desc_reg[pat_pkg::D_SH], 1'b1, wk_reg.fc, als_reg,
            wk_reg.addr[31:8] & ~pmask, desc_reg[31:8] & ~pmask};
        touch = 1'b1;
        tidx = vic_idx;
        crsp_next.done = wk_reg.cmd;
        st_next = pat_pkg::ST_IDLE;
      end
    endcase
    // mark use; once every entry is marked, restart the round
    if (touch) begin
      cache_next[tidx].nru = 1'b1;
      for (int i = 0; i < ENTRIES; i++) begin
        if (!cache_next[i].nru) all_used = 1'b0;
      end
      if (all_used) begin
        for (int i = 0; i < ENTRIES; i++) begin
          if (IW'(i) != tidx) cache_next[i].nru = 1'b0;
        end
      end
    end
  end

  // ==================================================
  // registers, synchronous reset
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_reg <= pat_pkg::ST_IDLE;
      cache_reg <= '{default: '0};
      rpt_reg <= '{default: '0};
      rptv_reg <= '0;
      bad_reg <= '{default: '0};
      bac_reg <= '{default: '0};
      ps_reg <= '0;
      lvl_reg <= '0;
      cal_reg <= '0;
      root_reg <= '0;
      als_reg <= '0;
      rptr_reg <= '0;
      psr_reg <= '0;
      desc_reg <= '0;
      wk_reg <= '0;
      lrsp_reg <= '0;
      crsp_reg <= '0;
      treq_reg <= '0;
    end else begin
      st_reg <= st_next;
      cache_reg <= cache_next;
      rpt_reg <= rpt_next;
      rptv_reg <= rptv_next;
      bad_reg <= bad_next;
      bac_reg <= bac_next;
      ps_reg <= ps_next;
      lvl_reg <= lvl_next;
      cal_reg <= cal_next;
      root_reg <= root_next;
      als_reg <= als_next;
      rptr_reg <= rptr_next;
      psr_reg <= psr_next;
      desc_reg <= desc_next;
      wk_reg <= wk_next;
      lrsp_reg <= lrsp_next;
      crsp_reg <= crsp_next;
      treq_reg <= treq_next;
    end
  end
endmodule

/* File: sim/pat_top_sva.sv */
// port checker for pat_top
// bound to every pat_top instance, one clock domain
`timescale 1ns/10ps
module pat_top_sva #(
  parameter int ENTRIES = 64
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // buses
  input wire pat_pkg::pat_lreq_t LA_REQ,
  input wire pat_pkg::pat_lrsp_t LA_RSP,
  input wire pat_pkg::pat_creq_t CMD_REQ,
  input wire pat_pkg::pat_crsp_t CMD_RSP,
  input wire pat_pkg::pat_treq_t TW_REQ,
  input wire logic TW_ACK,
  input wire logic [31:0] TW_RDATA
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ====
  // logical bus answers
  one_answer_a: assert property (
    $onehot0({LA_RSP.pa_valid, LA_RSP.dsack, LA_RSP.berr, LA_RSP.retry}))
    else $error("two answers at once");
  miss_walk_a: assert property (
    LA_RSP.retry |-> TW_REQ.req && !TW_REQ.we) else $error("miss without walk");
  fault_nopa_a: assert property (
    LA_RSP.berr |-> LA_RSP.pa == $past(LA_RSP.pa)) else $error("address on fault");
  data_idle_a: assert property (
    !LA_RSP.dsack |-> LA_RSP.data == 16'h0000) else $error("stray opcode");
  // ====
  // table walk bus and command done pulse
  walk_hold_a: assert property (
    TW_REQ.req && !TW_ACK |=> TW_REQ.req && $stable(TW_REQ.addr))
    else $error("walk dropped early");
  walk_quiet_a: assert property (
    TW_REQ.req |-> !LA_RSP.pa_valid) else $error("answer while walking");
  hist_used_a: assert property (
    TW_REQ.req && TW_REQ.we |-> TW_REQ.wdata[pat_pkg::D_USED]) else $error("used not set");
  walk_end_a: assert property (
    TW_ACK && TW_REQ.we |=> !TW_REQ.req [*2]) else $error("walk not ended");
  done_pulse_a: assert property (
    CMD_RSP.done |=> !CMD_RSP.done) else $error("done too long");
  // write flag of the walk, caught on the edge that takes it
  logic wr_walk;
  always_ff @(posedge CLK_SYS) begin
    if (!TW_REQ.req) begin
      wr_walk <= LA_REQ.valid ? LA_REQ.write : CMD_REQ.op == pat_pkg::OP_LOAD_W;
    end
  end
  hist_mod_a: assert property (
    TW_REQ.req && TW_REQ.we |-> TW_REQ.wdata[pat_pkg::D_MOD] == wr_walk)
    else $error("modified mark wrong");
endmodule
bind pat_top pat_top_sva #(.ENTRIES(ENTRIES)) pat_top_sva_i (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .LA_REQ(LA_REQ), .LA_RSP(LA_RSP), .CMD_REQ(CMD_REQ),
  .CMD_RSP(CMD_RSP), .TW_REQ(TW_REQ), .TW_ACK(TW_ACK), .TW_RDATA(TW_RDATA));

/* File: sim/pat_mem_model.sv */
// table memory on the walk bus
// every descriptor maps to one frame; walk address bit 9 marks it invalid,
// bit 10 marks it shared
`timescale 1ns/10ps
module pat_mem_model (
  // clock, reset, pace
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  // walk bus
  input wire pat_pkg::pat_treq_t tw_req,
  output logic tw_ack,
  output logic [31:0] tw_rdata
);
  logic [1:0] cnt; // wait cycles so far
  logic [31:0] desc; // descriptor at this address
  assign desc = {24'h001234, 2'h0, tw_req.addr[10], 4'h0, ~tw_req.addr[9]};
  // data outside the ack cycle is garbage
  assign tw_rdata = tw_ack ? desc : ~desc;
  // ack after one or four cycles, once per access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      tw_ack <= 1'b0;
    end else begin
      tw_ack <= tw_req.req && !tw_ack && (cnt == (slow ? 2'h3 : 2'h0));
      cnt <= (tw_req.req && !tw_ack) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for pat_top
// walk bus served by pat_mem_model, checker bound from its own file
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, ack;
  pat_pkg::pat_lreq_t lq = '0; // bus master request
  pat_pkg::pat_creq_t cq = '0; // command request
  pat_pkg::pat_lrsp_t lr, r;
  pat_pkg::pat_crsp_t cr, c;
  pat_pkg::pat_treq_t tq;
  logic [31:0] td;
  int fail_count = 0, n_tests = 0, cyc = 0;
  localparam logic [31:0] A = 32'h0000_1A3C, F = 32'h0000_8010;
  localparam logic [31:0] S = 32'h0001_1A3C, R = 32'h0001_0000; // shared page, root
  always #20 clk = ~clk;
  pat_top pat_top_i (.CLK_SYS(clk), .RST_N(rst_n), .LA_REQ(lq), .LA_RSP(lr), .CMD_REQ(cq),
    .CMD_RSP(cr), .TW_REQ(tq), .TW_ACK(ack), .TW_RDATA(td));
  pat_mem_model pat_mem_model_i (.clk(clk), .rst_n(rst_n), .slow(slow), .tw_req(tq),
    .tw_ack(ack), .tw_rdata(td));
  // ====
  // shared tasks
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic la(input logic [3:0] fc, input logic [31:0] a);
    int n = 0;
    @(posedge clk) lq <= '{1'b1, 1'b0, fc, a};
    do begin
      @(negedge clk);
      n++;
    end while (!(lr.pa_valid | lr.dsack | lr.berr | lr.retry) && n < 50);
    chk("la answer", 1, lr.pa_valid | lr.dsack | lr.berr | lr.retry);
    r = lr;
    @(posedge clk) lq.valid <= 1'b0;
  endtask
  task automatic cmd(input pat_pkg::pat_op_t op, input logic [4:0] s, input logic [31:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge clk) cq <= '{1'b1, op, s, 4'h5, a, d};
    do begin
      @(negedge clk);
      n++;
    end while (!cr.done && n < 50);
    chk("cmd done", 1, cr.done);
    c = cr;
    @(posedge clk) cq.valid <= 1'b0;
  endtask
  // wait out a table walk and its fill
  task automatic wt;
    int n = 0;
    while (tq.req && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("walk end", 0, tq.req);
    repeat (3) @(negedge clk);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_miss(input logic [31:0] a, input logic [31:0] pa);
    la(4'h5, a);
    chk("miss retry", 1, r.retry);
    wt;
    la(4'h5, a);
    chk("retried pa", pa, r.pa);
    la(4'h5, a + 4);
    chk("hit pa", pa + 4, r.pa);
  endtask
  // flush with address a, probe page p, expect retry e
  task automatic t_flush(input pat_pkg::pat_op_t op, input logic [31:0] a, input logic [31:0] p,
    input logic e);
    cmd(op, 5'h00, a, a);
    la(4'h5, p);
    chk("flush probe", e, r.retry);
    if (r.retry) wt;
  endtask
  task automatic t_load(input pat_pkg::pat_op_t op, input logic [31:0] a);
    cmd(op, 5'h00, a, 0);
    la(4'h5, a);
    chk("preload valid", 1, r.pa_valid);
    chk("preload hit", {24'h001234, a[7:0]}, r.pa);
  endtask
  task automatic t_priv;
    cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_AC, 0, 3);
    cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_CAL, 0, 4);
    la(4'h5, 32'h4000_1A3C);
    chk("priv berr", 1, r.berr);
    cmd(pat_pkg::OP_VALID, 5'h00, 32'h4000_1A3C, 0);
    chk("valid trap", 1, c.trap);
    cmd(pat_pkg::OP_VALID, 5'h00, 32'hC000_1A3C, 0);
    chk("valid ok", 0, c.trap);
    cmd(pat_pkg::OP_SAVE, 5'h00, 0, 0);
    chk("save", 8'h98, c.rdata[7:0]);
    cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_AC, 0, 1);
    cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_CAL, 0, 5);
    cmd(pat_pkg::OP_VALID, 5'h00, 32'h8000_0000, 0);
    chk("one line ok", 0, c.trap);
    cmd(pat_pkg::OP_VALID, 5'h00, 32'h0000_0000, 0);
    chk("one line trap", 1, c.trap);
    cmd(pat_pkg::OP_RESTORE, 5'h00, 0, 0);
    cmd(pat_pkg::OP_MOVE_RD, pat_pkg::SEL_CAL, 0, 0);
    chk("restored level", 0, c.rdata[2:0]);
  endtask
  task automatic t_bkpt;
    cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_BAD, 0, 32'h0000_4E71);
    cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_BAC, 0, 32'h0000_0102);
    for (int i = 0; i < 3; i++) begin
      la(pat_pkg::FC_CPU, 32'h0000_0000);
      chk("bkpt opcode", (i < 2) ? 32'h0000_4E71 : 32'h0, r.data);
      chk("bkpt berr", (i < 2) ? 0 : 1, r.berr);
      chk("bkpt ack", i < 2, r.dsack);
    end
  endtask
  // root aliases, root flush, shared and address flushes
  task automatic t_roots;
    for (int i = 0; i < 3; i++) begin
      cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_ROOT, 0, (i == 1) ? 32'h0002_0000 : R);
      la(4'h5, A);
      chk("alias probe", i < 2, r.retry);
      if (r.retry) wt;
    end
    t_flush(pat_pkg::OP_FL_ROOT, R, A, 1);
    t_flush(pat_pkg::OP_FL_SFCA, A, A, 0);
    la(4'h5, S);
    wt;
    t_flush(pat_pkg::OP_FL_SFC, S, S, 1);
    t_flush(pat_pkg::OP_FL_FCA, A, A, 1);
  endtask
  // ====
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_miss(A, 32'h0012_343C);
    t_flush(pat_pkg::OP_FL_FC, A, A, 1);
    t_flush(pat_pkg::OP_FL_ALL, A, A, 1);
    slow = 1'b1;
    la(4'h5, F);
    wt;
    la(4'h5, F);
    chk("bad page berr", 1, r.berr);
    cmd(pat_pkg::OP_TEST_R, 5'h00, F, 0);
    cmd(pat_pkg::OP_MOVE_RD, pat_pkg::SEL_PSR, 0, 0);
    chk("test status", 1, c.rdata[pat_pkg::PSR_MISS]);
    cmd(pat_pkg::OP_COND, 5'h00, 0, 0);
    chk("cond", 1, c.cond);
    t_load(pat_pkg::OP_LOAD_R, 32'h0000_2200);
    t_load(pat_pkg::OP_LOAD_W, 32'h0000_3300);
    t_priv;
    t_bkpt;
    t_roots;
    cmd(pat_pkg::OP_MOVE_WR, pat_pkg::SEL_TC, 0, 1);
    cmd(pat_pkg::OP_FL_ALL, 5'h00, 0, 0);
    t_miss(32'h0000_1B3C, 32'h0012_353C);
    wrap_up;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
endmodule
